// [logic/pc_stack_pkg.sv]
// Purpose: Shared constants for program counter, return stack and indirect decode
// Assumes: One core clock, asynchronous active-low reset
// Notes: Register offsets are data-space addresses on the plain register port
package pc_stack_pkg;
  // ==========================================================
  // Widths
  localparam int PC_W = 15;
  localparam int SP_W = 5;
  localparam int STACK_DEPTH = 16;
  localparam int FA_W = 16;
  localparam int DA_W = 12;
  // ==========================================================
  // Register offsets
  localparam logic [DA_W-1:0] OFS_COUNTER_LOW = 12'h002;
  localparam logic [DA_W-1:0] OFS_HIGH_LATCH = 12'h00A;
  localparam logic [DA_W-1:0] OFS_IND0 = 12'h000;
  localparam logic [DA_W-1:0] OFS_IND1 = 12'h001;
  localparam logic [DA_W-1:0] OFS_PTR0_LOW = 12'h004;
  localparam logic [DA_W-1:0] OFS_PTR0_HIGH = 12'h005;
  localparam logic [DA_W-1:0] OFS_PTR1_LOW = 12'h006;
  localparam logic [DA_W-1:0] OFS_PTR1_HIGH = 12'h007;
  localparam logic [DA_W-1:0] OFS_PWR_STATUS = 12'h096;
  localparam logic [DA_W-1:0] OFS_STACK_PTR = 12'hFED;
  localparam logic [DA_W-1:0] OFS_TOP_LOW = 12'hFEE;
  localparam logic [DA_W-1:0] OFS_TOP_HIGH = 12'hFEF;
  // ==========================================================
  // Field positions and reset values
  localparam int BIT_OVF = 7;
  localparam int BIT_UNF = 6;
  localparam logic [SP_W-1:0] SP_EMPTY = 5'h1F;
  localparam logic [SP_W-1:0] SP_TOP = 5'h0F;
  localparam logic [PC_W-1:0] PC_RESET = 15'h0000;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  // ==========================================================
  // Indirect address regions
  localparam logic [FA_W-1:0] TRAD_END = 16'h0FFF;
  localparam logic [FA_W-1:0] LIN_BASE = 16'h2000;
  localparam logic [FA_W-1:0] LIN_END = 16'h29AF;
  localparam logic [FA_W-1:0] BANK_BYTES = 16'h0050;
  localparam logic [6:0] BANK_RAM_BASE = 7'h20;
  // ==========================================================
  // Program counter operations
  typedef enum logic [3:0] {
    OP_NONE = 4'b0000,
    OP_STEP = 4'b0001,
    OP_CALL = 4'b0010,
    OP_CALL_ACC = 4'b0011,
    OP_BRANCH_ACC = 4'b0100,
    OP_REL_BRANCH = 4'b0101,
    OP_RETURN = 4'b0110,
    OP_RETURN_LIT = 4'b0111,
    OP_RETURN_INT = 4'b1000,
    OP_INT_VECTOR = 4'b1001,
    OP_GOTO = 4'b1010
  } pc_op_e;
  localparam logic [PC_W-1:0] INT_VECTOR = 15'h0004;
endpackage

// [logic/return_stack_mem.sv]
// Purpose: Return stack storage with registered read data
// Assumes: One write and one read address per cycle
// Notes: Outside program and data space
`timescale 1ns/1ps
module return_stack_mem
  import pc_stack_pkg::*;
#(
  parameter int DEPTH = STACK_DEPTH,
  parameter int WIDTH = PC_W
) (
  // Clock
  input wire logic core_clk,
  // Write side
  input wire logic wr_en,
  input wire logic [$clog2(DEPTH)-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  // Read side
  input wire logic [$clog2(DEPTH)-1:0] rd_addr,
  output logic [WIDTH-1:0] rd_data
);
  initial begin
    if (DEPTH < 2) $error("DEPTH too small");
  end
  // Storage array, no reset: contents unknown until pushed
  logic [WIDTH-1:0] mem_r [DEPTH];
  // ==========================================================
  // Write and registered read
  always_ff @(posedge core_clk) begin
    if (wr_en) begin
      mem_r[wr_addr] <= wr_data;
    end
    rd_data <= mem_r[rd_addr];
  end
endmodule

// [logic/indirect_decode.sv]
// Purpose: Decode a 16-bit indirect pointer into memory regions
// Assumes: Purely combinational
// Notes: Linear region maps to 80-byte general purpose RAM blocks per bank
`timescale 1ns/1ps
module indirect_decode
  import pc_stack_pkg::*;
(
  // Pointer in
  input wire logic [FA_W-1:0] ptr,
  // Decode out
  output logic is_trad,
  output logic is_lin,
  output logic is_prog,
  output logic [DA_W-1:0] data_addr,
  output logic [PC_W-1:0] prog_addr
);
  logic [FA_W-1:0] lin_ofs;
  logic [FA_W-1:0] bank;
  logic [FA_W-1:0] rem_ofs;
  // ==========================================================
  // Region selection
  assign is_prog = ptr[FA_W-1];
  assign is_trad = !is_prog && (ptr <= TRAD_END);
  assign is_lin = (ptr >= LIN_BASE) && (ptr <= LIN_END);
  assign prog_addr = ptr[PC_W-1:0];
  // Linear bank arithmetic
  assign lin_ofs = ptr - LIN_BASE;
  assign bank = lin_ofs / BANK_BYTES;
  assign rem_ofs = lin_ofs % BANK_BYTES;
  // Common bytes never reached: remainder stays below 80
  assign data_addr = is_trad ? ptr[DA_W-1:0] :
    {bank[4:0], 7'(BANK_RAM_BASE + rem_ofs[6:0])};
endmodule

// [logic/pc_stack_core.sv]
// Purpose: Program counter sequencing, return stack and indirect access
// Assumes: Decoder issues one operation per cycle; memories answer combinationally
// Notes: Program-memory indirect reads take one extra cycle
// Overview of operation
// - Fifteen-bit counter, low byte plus latch.
// - Every reset clears the counter.
// - Low-byte write loads high from latch.
// - Call: operand low bits, latch bits 6:3.
// - Accumulator call: low from accumulator, high latch.
// - Accumulator branch adds one plus unsigned.
// - Relative branch adds one plus signed.
// - Sixteen entries, fifteen bits, private stack.
// - Calls push, returns pop, latch untouched.
// - Fault reset off: stack wraps circularly.
// - Overflow and underflow flags always set.
// - Pointer and top pair readable, writable.
// - Push increments first, pop decrements after.
// - Empty pointer 0x1F, first push 0x00.
// - Fault reset on: request reset, flags.
// - Self-pointing indirect: reads zero, writes dropped.
// - Pointer is sixteen bits from two bytes.
// - Traditional range maps absolute addresses.
// - Linear range spans consecutive bank blocks.
// - Unimplemented indirect reads return zero.
// - Pointer top bit selects program memory.
// - Program writes ignored, reads add cycle.
`timescale 1ns/1ps
module pc_stack_core
  import pc_stack_pkg::*;
#(
  parameter int DEPTH = STACK_DEPTH
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Decoder operation
  input wire logic op_valid,
  input wire logic [3:0] op_code,
  input wire logic [10:0] operand,
  input wire logic [7:0] accumulator,
  input wire logic stack_fault_reset_enable,
  // Register port
  input wire logic [DA_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Indirect access select (0 or 1)
  input wire logic ind_sel,
  // Data memory
  output logic [DA_W-1:0] dmem_addr,
  output logic dmem_wr,
  output logic [7:0] dmem_wdata,
  output logic dmem_rd,
  input wire logic [7:0] dmem_rdata,
  input wire logic dmem_present,
  // Program memory indirect read
  output logic [PC_W-1:0] pmem_addr,
  output logic pmem_rd,
  input wire logic [13:0] pmem_rdata,
  // Status and control
  output logic [PC_W-1:0] program_counter,
  output logic stall,
  output logic stack_fault_reset,
  output logic stack_overflow_flag,
  output logic stack_underflow_flag
);
  initial begin
    if (DEPTH != STACK_DEPTH) $error("stack depth must be 16");
  end
  // ==========================================================
  // State
  logic [PC_W-1:0] pc_r;
  logic [PC_W-1:0] pc_nxt;
  logic [6:0] counter_high_latch_r;
  logic [SP_W-1:0] sp_r;
  logic [SP_W-1:0] sp_nxt;
  logic stack_overflow_flag_r;
  logic stack_underflow_flag_r;
  logic fault_r;
  logic [FA_W-1:0] ptr0_r;
  logic [FA_W-1:0] ptr1_r;
  logic prog_wait_r;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  // ==========================================================
  // Operation decode
  pc_op_e op;
  logic is_push;
  logic is_pop;
  logic pc_low_wr;
  logic overflow_ev;
  logic underflow_ev;
  assign op = op_valid ? pc_op_e'(op_code) : OP_NONE;
  assign is_push = (op == OP_CALL) || (op == OP_CALL_ACC) || (op == OP_INT_VECTOR);
  assign is_pop = (op == OP_RETURN) || (op == OP_RETURN_LIT) || (op == OP_RETURN_INT);
  assign pc_low_wr = reg_wr && (reg_addr == OFS_COUNTER_LOW);
  // Overflow when pushing from the top entry, underflow when popping empty
  assign overflow_ev = is_push && (sp_r == SP_TOP);
  assign underflow_ev = is_pop && (sp_r == SP_EMPTY);
  // ==========================================================
  // Stack pointer math
  function automatic logic [SP_W-1:0] sp_step(input logic [SP_W-1:0] sp, input logic up);
    logic [SP_W-1:0] r;
    r = up ? SP_W'(sp + 1'b1) : SP_W'(sp - 1'b1);
    // Circular wrap within the 16 entries, keeping empty reachable from 0
    if (up && sp == SP_TOP) begin
      r = 5'h00;
    end else if (!up && sp == SP_EMPTY) begin
      r = SP_TOP;
    end
    return r;
  endfunction
  logic [SP_W-1:0] sp_push;
  logic [3:0] stack_slot;
  assign sp_push = sp_step(sp_r, 1'b1);
  assign stack_slot = is_push ? sp_push[3:0] : sp_r[3:0];
  // ==========================================================
  // Stack memory
  logic [PC_W-1:0] top_rdata;
  logic stack_wr;
  logic [PC_W-1:0] stack_wdata;
  logic top_low_wr;
  logic top_high_wr;
  logic [PC_W-1:0] top_cur;
  assign top_low_wr = reg_wr && (reg_addr == OFS_TOP_LOW);
  assign top_high_wr = reg_wr && (reg_addr == OFS_TOP_HIGH);
  // Top entry read combinationally from the registered copy below
  logic [PC_W-1:0] top_shadow_r;
  assign top_cur = top_shadow_r;
  // Push stores the return address; software writes patch the top pair
  assign stack_wr = is_push || top_low_wr || top_high_wr;
  assign stack_wdata = is_push ? pc_r :
    top_low_wr ? {top_cur[14:8], reg_wdata} : {reg_wdata[6:0], top_cur[7:0]};
  return_stack_mem #(
    .DEPTH(STACK_DEPTH),
    .WIDTH(PC_W)
  ) u_stack (
    .core_clk(core_clk),
    .wr_en(stack_wr),
    .wr_addr(stack_slot),
    .wr_data(stack_wdata),
    .rd_addr(sp_nxt[3:0]),
    .rd_data(top_rdata)
  );
  // Shadow follows memory read data except on same-cycle write to new top
  logic shadow_bypass_r;
  logic [PC_W-1:0] shadow_data_r;
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      shadow_bypass_r <= 1'b0;
      shadow_data_r <= PC_RESET;
    end else begin
      shadow_bypass_r <= stack_wr && (stack_slot == sp_nxt[3:0]);
      shadow_data_r <= stack_wdata;
    end
  end
  assign top_shadow_r = shadow_bypass_r ? shadow_data_r : top_rdata;
  // ==========================================================
  // Program counter next value
  logic [PC_W-1:0] pc_plus1;
  assign pc_plus1 = PC_W'(pc_r + 1'b1);
  always_comb begin
    pc_nxt = pc_r;
    case (op)
      OP_STEP: pc_nxt = pc_plus1;
      OP_GOTO: pc_nxt = {counter_high_latch_r[6:3], operand};
      OP_CALL: pc_nxt = {counter_high_latch_r[6:3], operand};
      OP_CALL_ACC: pc_nxt = {counter_high_latch_r, accumulator};
      OP_BRANCH_ACC: pc_nxt = PC_W'(pc_plus1 + {7'h00, accumulator});
      OP_REL_BRANCH: pc_nxt = PC_W'(pc_plus1 + {{6{operand[8]}}, operand[8:0]});
      OP_RETURN, OP_RETURN_LIT, OP_RETURN_INT: pc_nxt = top_cur;
      OP_INT_VECTOR: pc_nxt = INT_VECTOR;
      default: pc_nxt = pc_r;
    endcase
    // A low-byte write overrides: latch joins the written byte
    if (pc_low_wr) begin
      pc_nxt = {counter_high_latch_r, reg_wdata};
    end
  end
  // ==========================================================
  // Stack pointer next value
  always_comb begin
    sp_nxt = sp_r;
    if (is_push) begin
      sp_nxt = sp_push;
    end else if (is_pop) begin
      sp_nxt = sp_step(sp_r, 1'b0);
    end else if (reg_wr && reg_addr == OFS_STACK_PTR) begin
      sp_nxt = reg_wdata[SP_W-1:0];
    end
  end
  // ==========================================================
  // Counter, latch and stack state
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pc_r <= PC_RESET;
      sp_r <= SP_EMPTY;
      counter_high_latch_r <= 7'h00;
    end else begin
      pc_r <= stall ? pc_r : pc_nxt;
      sp_r <= sp_nxt;
      // Latch untouched by push and pop
      if (reg_wr && reg_addr == OFS_HIGH_LATCH) begin
        counter_high_latch_r <= reg_wdata[6:0];
      end
    end
  end
  // Sticky flags: event beats software clear in same cycle
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      stack_overflow_flag_r <= 1'b0;
      stack_underflow_flag_r <= 1'b0;
      fault_r <= 1'b0;
    end else begin
      if (overflow_ev) begin
        stack_overflow_flag_r <= 1'b1;
      end else if (reg_wr && reg_addr == OFS_PWR_STATUS) begin
        stack_overflow_flag_r <= reg_wdata[BIT_OVF];
      end
      if (underflow_ev) begin
        stack_underflow_flag_r <= 1'b1;
      end else if (reg_wr && reg_addr == OFS_PWR_STATUS) begin
        stack_underflow_flag_r <= reg_wdata[BIT_UNF];
      end
      // Reset request only when the fault option is on
      fault_r <= stack_fault_reset_enable && (overflow_ev || underflow_ev);
    end
  end
  assign stack_fault_reset = fault_r;
  assign stack_overflow_flag = stack_overflow_flag_r;
  assign stack_underflow_flag = stack_underflow_flag_r;
  assign program_counter = pc_r;
  // ==========================================================
  // Indirect pointers and decode
  logic [FA_W-1:0] ptr_cur;
  logic ind_access;
  logic d_trad;
  logic d_lin;
  logic d_prog;
  logic [DA_W-1:0] d_addr;
  logic [PC_W-1:0] d_paddr;
  logic self_ref;
  assign ptr_cur = ind_sel ? ptr1_r : ptr0_r;
  assign ind_access = (reg_wr || reg_rd) && (reg_addr == OFS_IND0 || reg_addr == OFS_IND1);
  indirect_decode u_dec (
    .ptr(ptr_cur),
    .is_trad(d_trad),
    .is_lin(d_lin),
    .is_prog(d_prog),
    .data_addr(d_addr),
    .prog_addr(d_paddr)
  );
  // Pointing at either port reads zero and drops writes
  assign self_ref = d_trad && (d_addr == OFS_IND0 || d_addr == OFS_IND1);
  assign dmem_addr = d_addr;
  assign dmem_wr = ind_access && reg_wr && (d_trad || d_lin) && !self_ref;
  assign dmem_wdata = reg_wdata;
  assign dmem_rd = ind_access && reg_rd && (d_trad || d_lin) && !self_ref;
  assign pmem_addr = d_paddr;
  assign pmem_rd = ind_access && reg_rd && d_prog;
  // Extra cycle on program-memory reads: hold the counter once
  assign stall = ind_access && reg_rd && d_prog && !prog_wait_r;
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      ptr0_r <= 16'h0000;
      ptr1_r <= 16'h0000;
      prog_wait_r <= 1'b0;
    end else begin
      prog_wait_r <= stall;
      if (reg_wr && reg_addr == OFS_PTR0_LOW) ptr0_r[7:0] <= reg_wdata;
      if (reg_wr && reg_addr == OFS_PTR0_HIGH) ptr0_r[15:8] <= reg_wdata;
      if (reg_wr && reg_addr == OFS_PTR1_LOW) ptr1_r[7:0] <= reg_wdata;
      if (reg_wr && reg_addr == OFS_PTR1_HIGH) ptr1_r[15:8] <= reg_wdata;
    end
  end
  // ==========================================================
  // Read mux, data one cycle after the strobe
  always_comb begin
    rdata_nxt = BYTE_ZERO;
    if (ind_access) begin
      if (self_ref) rdata_nxt = BYTE_ZERO;
      else if (d_prog) rdata_nxt = pmem_rdata[7:0];
      else if ((d_trad || d_lin) && dmem_present) rdata_nxt = dmem_rdata;
      else rdata_nxt = BYTE_ZERO;
    end else begin
      case (reg_addr)
        OFS_COUNTER_LOW: rdata_nxt = pc_r[7:0];
        OFS_HIGH_LATCH: rdata_nxt = {1'b0, counter_high_latch_r};
        OFS_STACK_PTR: rdata_nxt = {3'h0, sp_r};
        OFS_TOP_LOW: rdata_nxt = top_cur[7:0];
        OFS_TOP_HIGH: rdata_nxt = {1'b0, top_cur[14:8]};
        OFS_PWR_STATUS: rdata_nxt = {stack_overflow_flag_r, stack_underflow_flag_r, 6'h00};
        OFS_PTR0_LOW: rdata_nxt = ptr0_r[7:0];
        OFS_PTR0_HIGH: rdata_nxt = ptr0_r[15:8];
        OFS_PTR1_LOW: rdata_nxt = ptr1_r[7:0];
        OFS_PTR1_HIGH: rdata_nxt = ptr1_r[15:8];
        default: rdata_nxt = BYTE_ZERO;
      endcase
    end
  end
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rdata_r <= BYTE_ZERO;
    end else begin
      rdata_r <= reg_rd ? rdata_nxt : BYTE_ZERO;
    end
  end
  assign reg_rdata = rdata_r;
endmodule

// [testbench/pc_stack_core_chk.sv]
// Purpose: Port checks for counter, stack and indirect core
// Assumes: One clock; bench never mixes a low-byte write with an op
// Notes: Bound from the bench top file
`timescale 1ns/1ps
module pc_stack_core_chk
  import pc_stack_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Decoder side
  input wire logic op_valid,
  input wire logic [3:0] op_code,
  input wire logic [10:0] operand,
  input wire logic [7:0] accumulator,
  input wire logic stack_fault_reset_enable,
  // Register port
  input wire logic [DA_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // Memory side
  input wire logic [DA_W-1:0] dmem_addr,
  input wire logic dmem_wr,
  input wire logic pmem_rd,
  // Status
  input wire logic [PC_W-1:0] program_counter,
  input wire logic stall,
  input wire logic stack_fault_reset,
  input wire logic stack_overflow_flag,
  input wire logic stack_underflow_flag
);
  // ==========================================================
  // Helpers
  wire low_wr = reg_wr && reg_addr == OFS_COUNTER_LOW; // Low-byte write wins over op
  wire go = op_valid && !low_wr;
  wire st_wr = reg_wr && reg_addr == OFS_PWR_STATUS; // Only way to drop flags
  wire [14:0] rel_ofs = {{6{operand[8]}}, operand[8:0]};
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  // ==========================================================
  // Assertions
  rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 8'h00) else $error("read data without read");
  low_write_a: assert property (low_wr |=> program_counter[7:0] == $past(reg_wdata)) else $error("low byte");
  call_load_a: assert property (go && op_code == OP_CALL |=> program_counter[10:0] == $past(operand))
    else $error("call target");
  acc_call_a: assert property (go && op_code == OP_CALL_ACC |=> program_counter[7:0] == $past(accumulator))
    else $error("acc call");
  acc_branch_a: assert property (go && op_code == OP_BRANCH_ACC |=>
    program_counter == $past(program_counter) + 15'h0001 + $past(accumulator)) else $error("acc branch");
  rel_branch_a: assert property (go && op_code == OP_REL_BRANCH |=>
    program_counter == $past(program_counter) + 15'h0001 + $past(rel_ofs)) else $error("rel branch");
  ovf_sticky_a: assert property (stack_overflow_flag && !st_wr |=> stack_overflow_flag) else $error("ovf");
  unf_sticky_a: assert property (stack_underflow_flag && !st_wr |=> stack_underflow_flag) else $error("unf");
  fault_pulse_a: assert property (stack_fault_reset |=> !stack_fault_reset) else $error("fault pulse");
  fault_gate_a: assert property (stack_fault_reset |-> $past(stack_fault_reset_enable)) else $error("fault");
  self_write_a: assert property (dmem_wr |-> dmem_addr != OFS_IND0 && dmem_addr != OFS_IND1)
    else $error("self write");
  prog_wait_a: assert property (stall |-> pmem_rd ##1 (pmem_rd && !stall)) else $error("prog wait");
endmodule

// [testbench/pc_stack_far_mem.sv]
// Purpose: Data and program memory behind the core
// Assumes: Combinational answers, writes land on the clock edge
// Notes: Idle read lines churn so stale data never passes
`timescale 1ns/1ps
module pc_stack_far_mem
  import pc_stack_pkg::*;
(
  // Clock
  input wire logic core_clk,
  // Data memory
  input wire logic [DA_W-1:0] dmem_addr,
  input wire logic dmem_wr,
  input wire logic [7:0] dmem_wdata,
  input wire logic dmem_rd,
  output logic [7:0] dmem_rdata,
  output logic dmem_present,
  // Program memory
  input wire logic [PC_W-1:0] pmem_addr,
  input wire logic pmem_rd,
  output logic [13:0] pmem_rdata
);
  logic [7:0] mem [0:4095]; // Seeded with address-derived bytes
  logic [7:0] churn_r = 8'h5A; // Changes every cycle
  initial for (int i = 0; i < 4096; i++) mem[i] = i[7:0] ^ 8'hA5;
  // Page 0xE is left unimplemented
  assign dmem_present = dmem_addr[11:8] != 4'hE;
  assign dmem_rdata = (dmem_rd && dmem_present) ? mem[dmem_addr] : churn_r;
  // Upper bits differ from low byte so truncation shows
  assign pmem_rdata = pmem_rd ? {~pmem_addr[5:0], pmem_addr[7:0]} : {6'h15, churn_r};
  // Write port and churn
  always @(posedge core_clk) begin
    churn_r <= churn_r + 8'h3B;
    if (dmem_wr && dmem_present) begin
      mem[dmem_addr] <= dmem_wdata;
    end
  end
endmodule

// [testbench/pc_stack_indirect_addressing_bench.sv]
// Purpose: Self-checking bench for counter, stack and indirect core
// Assumes: 10 MHz clock, bench acts as decoder and register master
// Notes: Pushes save the counter of the calling cycle
`timescale 1ns/1ps
`define CHECK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin fail_count++; \
  $display("wrong value %s expected %h seen %h", nm, e, g); end end
module pc_stack_indirect_addressing_bench
  import pc_stack_pkg::*;
;
  // ==========================================================
  // Signals
  logic core_clk = 0, rstn = 0, op_valid = 0, fre = 0, reg_wr = 0, reg_rd = 0, ind_sel = 0;
  logic [3:0] op_code = 0;
  logic [10:0] operand = 0;
  logic [7:0] acc = 0, reg_wdata = 0, reg_rdata, dmem_wdata, dmem_rdata, d;
  logic [DA_W-1:0] reg_addr = 0, dmem_addr;
  logic dmem_wr, dmem_rd, dmem_present, pmem_rd, stall, fault, ovf, unf, st;
  logic [PC_W-1:0] pmem_addr, pc;
  logic [13:0] pmem_rdata;
  int fail_count = 0, tests_run = 0;
  pc_stack_core dut (.core_clk, .rstn, .op_valid, .op_code, .operand, .accumulator(acc),
    .stack_fault_reset_enable(fre), .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .ind_sel,
    .dmem_addr, .dmem_wr, .dmem_wdata, .dmem_rd, .dmem_rdata, .dmem_present, .pmem_addr, .pmem_rd,
    .pmem_rdata, .program_counter(pc), .stall, .stack_fault_reset(fault),
    .stack_overflow_flag(ovf), .stack_underflow_flag(unf));
  pc_stack_far_mem far (.core_clk, .dmem_addr, .dmem_wr, .dmem_wdata, .dmem_rd, .dmem_rdata,
    .dmem_present, .pmem_addr, .pmem_rd, .pmem_rdata);
  initial forever #50 core_clk = ~core_clk;
  // ==========================================================
  // Bus and decoder tasks
  task wr(input logic [11:0] a, input logic [7:0] v);
    @(posedge core_clk) begin
      reg_wr <= 1; reg_addr <= a; reg_wdata <= v;
    end
    @(posedge core_clk) reg_wr <= 0;
    #1;
  endtask
  task rd(input logic [11:0] a, output logic [7:0] v);
    @(posedge core_clk) begin
      reg_rd <= 1; reg_addr <= a;
    end
    @(posedge core_clk) reg_rd <= 0;
    #1 v = reg_rdata;
  endtask
  task op(input pc_op_e c, input logic [10:0] o, input logic [7:0] w);
    @(posedge core_clk) begin
      op_valid <= 1; op_code <= c; operand <= o; acc <= w;
    end
    @(posedge core_clk) op_valid <= 0;
    #1;
  endtask
  task chk_rd(input string nm, input logic [11:0] a, input logic [7:0] e);
    rd(a, d);
    `CHECK(nm, e, d)
  endtask
  task ptr(input logic s, input logic [15:0] v);
    @(posedge core_clk) ind_sel <= s;
    wr(s ? OFS_PTR1_LOW : OFS_PTR0_LOW, v[7:0]);
    wr(s ? OFS_PTR1_HIGH : OFS_PTR0_HIGH, v[15:8]);
  endtask
  // Program-memory reads hold the strobe one more cycle
  task ind(input logic s, input logic [7:0] e, input logic est);
    @(posedge core_clk) begin
      reg_rd <= 1; reg_addr <= s ? OFS_IND1 : OFS_IND0;
    end
    #1 st = stall;
    @(posedge core_clk);
    if (st === 1'b1) @(posedge core_clk);
    reg_rd <= 0;
    #1 `CHECK("ind stall", est, st)
    `CHECK("ind data", e, reg_rdata)
  endtask
  // ==========================================================
  // Scenarios
  task t_reset;
    `CHECK("pc", 15'h0000, pc)
    `CHECK("flags", 3'b000, {ovf, unf, fault})
    chk_rd("sp", OFS_STACK_PTR, 8'h1F);
  endtask
  task t_jumps;
    wr(OFS_HIGH_LATCH, 8'h15);
    wr(OFS_COUNTER_LOW, 8'h34);
    `CHECK("low write", 15'h1534, pc)
    op(OP_BRANCH_ACC, 11'h000, 8'hF0);
    `CHECK("acc branch", 15'h1625, pc)
    op(OP_REL_BRANCH, 11'h1F0, 8'h00);
    `CHECK("rel branch", 15'h1616, pc)
    op(OP_STEP, 11'h000, 8'h00);
    `CHECK("step", 15'h1617, pc)
  endtask
  task t_calls;
    wr(OFS_HIGH_LATCH, 8'h5D);
    op(OP_CALL, 11'h2A3, 8'h00);
    `CHECK("call", 15'h5AA3, pc)
    chk_rd("sp", OFS_STACK_PTR, 8'h00);
    chk_rd("tos lo", OFS_TOP_LOW, 8'h17);
    chk_rd("tos hi", OFS_TOP_HIGH, 8'h16);
    op(OP_CALL_ACC, 11'h000, 8'h77);
    `CHECK("call_via_accumulator", 15'h5D77, pc)
    op(OP_INT_VECTOR, 11'h000, 8'h00);
    `CHECK("vector", INT_VECTOR, pc)
    chk_rd("sp", OFS_STACK_PTR, 8'h02);
    op(OP_RETURN_INT, 11'h000, 8'h00);
    `CHECK("ret int", 15'h5D77, pc)
    op(OP_RETURN, 11'h000, 8'h00);
    `CHECK("ret", 15'h5AA3, pc)
    op(OP_RETURN_LIT, 11'h000, 8'h00);
    `CHECK("ret lit", 15'h1617, pc)
    chk_rd("sp", OFS_STACK_PTR, 8'h1F);
    chk_rd("latch", OFS_HIGH_LATCH, 8'h5D);
  endtask
  task t_stack_regs;
    wr(OFS_STACK_PTR, 8'h03);
    wr(OFS_TOP_LOW, 8'hAB);
    wr(OFS_TOP_HIGH, 8'h12);
    chk_rd("sp w", OFS_STACK_PTR, 8'h03);
    chk_rd("tos lo w", OFS_TOP_LOW, 8'hAB);
    chk_rd("tos hi w", OFS_TOP_HIGH, 8'h12);
    wr(OFS_STACK_PTR, 8'h1F);
  endtask
  // Seventeen pushes wrap onto entry zero
  task t_wrap;
    wr(OFS_HIGH_LATCH, 8'h00);
    op(OP_GOTO, 11'h555, 8'h00);
    `CHECK("goto", 15'h0555, pc)
    for (int k = 0; k < 17; k++) begin
      op(OP_CALL, k[10:0], 8'h00);
      if (k == 15) `CHECK("ovf early", 1'b0, ovf)
    end
    chk_rd("sp wrap", OFS_STACK_PTR, 8'h00);
    chk_rd("tos wrap", OFS_TOP_LOW, 8'h0F);
    `CHECK("ovf", 2'b10, {ovf, fault})
    chk_rd("pwr status", OFS_PWR_STATUS, 8'h80);
    wr(OFS_PWR_STATUS, 8'h00);
    `CHECK("ovf clr", 1'b0, ovf)
  endtask
  task t_fault;
    @(posedge core_clk) fre <= 1;
    op(OP_RETURN, 11'h000, 8'h00);
    `CHECK("no fault", 1'b0, fault)
    op(OP_RETURN, 11'h000, 8'h00);
    `CHECK("fault", 2'b11, {fault, unf})
    chk_rd("pwr status", OFS_PWR_STATUS, 8'h40);
    @(posedge core_clk) rstn <= 0;
    repeat (3) @(posedge core_clk);
    rstn <= 1;
    t_reset();
  endtask
  task t_indirect;
    ptr(0, 16'h2050);
    ind(0, 8'h05, 1'b0);
    ptr(0, 16'h20A0);
    ind(0, 8'h85, 1'b0);
    ptr(1, 16'h0456);
    wr(OFS_IND1, 8'h3C);
    ind(1, 8'h3C, 1'b0);
    ptr(0, 16'h0001);
    ind(0, 8'h00, 1'b0);
    wr(OFS_IND0, 8'h99);
    ptr(0, 16'h0E10);
    ind(0, 8'h00, 1'b0);
    ptr(1, 16'h1000);
    ind(1, 8'h00, 1'b0);
    ptr(0, 16'h8123);
    ind(0, 8'h23, 1'b1);
  endtask
  // ==========================================================
  // Verdict
  task end_of_test;
    if (fail_count == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #10_000_000;
    fail_count++;
    end_of_test();
  end
  initial begin
    repeat (20) @(posedge core_clk);
    rstn <= 1;
    #1 t_reset();
    t_jumps();
    t_calls();
    t_stack_regs();
    t_wrap();
    t_fault();
    t_indirect();
    end_of_test();
  end
endmodule
bind pc_stack_core pc_stack_core_chk chk (.core_clk, .rstn, .op_valid, .op_code, .operand, .accumulator,
  .stack_fault_reset_enable, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .dmem_addr, .dmem_wr,
  .pmem_rd, .program_counter, .stall, .stack_fault_reset, .stack_overflow_flag, .stack_underflow_flag);
